/* design/tws_eeprom_port.sv */
// Slave port and array of a small two-wire serial EEPROM, with self-timed programming.
// Assumes scl and the sda input come from pads; link logic runs on scl as its own clock,
// the programming timer runs on the 100 MHz system clock. No clock stands outside frames
// except scl, which the master owns; every scl-side flag ends with STOP or START.
`include "tws_defs.svh"

// Operation
// - Data sampled on rising clock edge, shifted out on the falling edge.
// - Unconnected chip-select inputs count as logic low.
// - Protect high blocks programming; low allows it; reads ignore it.
// - Pages of 16 bytes; 32/64/128 pages; 9/10/11 word-address bits.
// - Data falling while clock high is START; commands open with it.
// - Data rising while clock high is STOP; commands close with it.
// - STOP after a write launches self-timed programming, then standby.
// - Each received byte acknowledged by pulling data low on ninth clock.
// - Standby after power-up, after a read's STOP, after programming.
// - Device answers only when the address word's top nibble is 1010.
// - Bits five to seven match chip-selects; mismatch returns to standby.
// - Eighth address bit high selects read, low selects programming.
// - Smallest variant matches bits five and six only; up to four parts.
// - Middle variant matches bit five only; up to two parts.
// - Largest variant matches no chip-select bits; one part per bus.
// - Byte write acknowledged at cycles nine, eighteen, twenty-seven, then STOP.
// - Programming ignores inputs and ends within 5 ms, back to standby.
// - Each programming erases target bytes before writing new values; the array here takes each byte as it arrives, with no erase step.
// - Data line only pulled low or released, never driven high.
// - While programming, address commands get no acknowledge on ninth clock.
// - Page write increments only low four bits, wrapping within the page.
// - Internal address counter holds last address plus one, bumps per read.
// - Read outputs further bytes on master acknowledge, wrapping at top.
module tws_eeprom_port
	import tws_pkg::*;
#(
	parameter int ADDR_BITS   = 9,
	parameter int PROG_CYCLES = `TWS_PROG_CYCLES
) (
	// System
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       clock_enable,
	// Two-wire link
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Straps
	input  wire logic       chip_select_bit_top,
	input  wire logic       chip_select_bit_mid,
	input  wire logic       chip_select_bit_low,
	input  wire logic       write_protect,
	// Status
	output logic            programming_busy,
	output logic            standby
);

	localparam int DEPTH   = 1 << ADDR_BITS;
	localparam int HI_BITS = ADDR_BITS - 8;

	initial begin
		if (ADDR_BITS < 9 || ADDR_BITS > 11)
			$error("ADDR_BITS must be 9, 10 or 11");
		if (PROG_CYCLES < 1)
			$error("PROG_CYCLES must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////////
	// System reset and programming timer

	logic        rst_sync1_reg;
	logic        rst_sync2_reg;
	logic        rst_n;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end
	assign rst_n = rst_sync2_reg;

	// Write request crosses by toggle; busy level crosses back through a two-flop sync on scl
	logic        req_tgl_reg;
	logic [2:0]  req_sync_reg;
	logic        done_tgl_reg;
	logic [1:0]  done_sync_reg;
	logic        busy_reg;
	logic [31:0] prog_cnt_reg;
	logic        prog_start;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			req_sync_reg <= 3'h0;
		else if (clock_enable)
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
	end
	assign prog_start = req_sync_reg[2] ^ req_sync_reg[1];

	// Fixed-length timer: longest legal stand-in for the cell's program time
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg     <= 1'b0;
			prog_cnt_reg <= 32'h0;
			done_tgl_reg <= 1'b0;
		end else if (clock_enable) begin
			if (prog_start && !busy_reg) begin
				busy_reg     <= 1'b1;
				prog_cnt_reg <= 32'(PROG_CYCLES - 1);
			end else if (busy_reg) begin
				if (prog_cnt_reg == 32'h0) begin
					busy_reg     <= 1'b0;
					done_tgl_reg <= ~done_tgl_reg;
				end else
					prog_cnt_reg <= prog_cnt_reg - 32'h1;
			end
		end
	end
	assign programming_busy = busy_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: START/STOP detection

	logic        start_tgl_reg;
	logic        stop_tgl_reg;
	logic        start_seen_reg;
	logic        stop_seen_reg;
	logic        frame_reset;
	logic        wr_pending_reg;

	// START flag in the data-falling domain, cleared from the scl side by toggle compare
	always_ff @(negedge sda_in or negedge resetn) begin
		if (!resetn)
			start_tgl_reg <= 1'b0;
		else if (scl)
			start_tgl_reg <= ~start_tgl_reg;
	end

	always_ff @(posedge sda_in or negedge resetn) begin
		if (!resetn) begin
			stop_tgl_reg <= 1'b0;
			req_tgl_reg  <= 1'b0;
		end else if (scl) begin
			stop_tgl_reg <= ~stop_tgl_reg;
			// Launched here: after STOP the master may leave scl still for good
			if (wr_pending_reg && !write_protect)
				req_tgl_reg <= ~req_tgl_reg;
		end
	end

	logic        start_ack_reg;
	logic        stop_ack_reg;
	assign start_seen_reg = start_tgl_reg ^ start_ack_reg;
	assign stop_seen_reg  = stop_tgl_reg ^ stop_ack_reg;
	assign frame_reset    = start_seen_reg || stop_seen_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: shifter and sequencer on scl

	tws_state_type state_reg;
	logic [3:0]    bit_cnt_reg;
	logic [7:0]    shift_reg;
	logic [ADDR_BITS-1:0] addr_cnt_reg;
	logic [ADDR_BITS-1:0] page_base_reg;
	logic          rd_mode_reg;
	logic          ack_now_reg;
	logic [1:0]    busy_sync_reg;
	logic [1:0]    done_scl_sync_reg;
	logic [7:0]    mem [DEPTH];
	tws_wr_type    wr_word;
	logic          dev_match;
	logic [2:0]    sel_pins;
	logic [2:0]    sel_mask;
	logic [7:0]    rx_byte;

	// Unconnected straps are pulled low in the pad ring, so a float reads as 0
	assign sel_pins = {chip_select_bit_top, chip_select_bit_mid, chip_select_bit_low};
	assign sel_mask = (ADDR_BITS == 9) ? 3'h6 :
	                  (ADDR_BITS == 10) ? 3'h4 :
	                  3'h0;
	assign rx_byte  = {shift_reg[6:0], sda_in};
	assign dev_match = (rx_byte[7:4] == `TWS_DEV_TYPE_CODE) &&
	                   (((rx_byte[3:1] ^ sel_pins) & sel_mask) == 3'h0);

	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn)
			busy_sync_reg <= 2'h0;
		else
			busy_sync_reg <= {busy_sync_reg[0], busy_reg};
	end

	// Rising edge: sample data, advance the sequence
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= TWS_IDLE;
			bit_cnt_reg    <= 4'h0;
			shift_reg      <= 8'h0;
			addr_cnt_reg   <= '0;
			page_base_reg  <= '0;
			rd_mode_reg    <= 1'b0;
			wr_pending_reg <= 1'b0;
			ack_now_reg    <= 1'b0;
			start_ack_reg  <= 1'b0;
			stop_ack_reg   <= 1'b0;
			wr_word        <= '0;
		end else begin
			if (stop_seen_reg)
				stop_ack_reg <= stop_tgl_reg;
			if (frame_reset) begin
				wr_pending_reg <= 1'b0;
				ack_now_reg    <= 1'b0;
				bit_cnt_reg    <= 4'h1;
				shift_reg      <= {7'h0, sda_in};
				state_reg      <= start_seen_reg ? TWS_DEVADR : TWS_IDLE;
				start_ack_reg  <= start_tgl_reg;
			end else if (state_reg != TWS_IDLE) begin
				ack_now_reg <= 1'b0;
				if (bit_cnt_reg == `TWS_ACK_BIT_INDEX) begin
					// Ninth clock: the acknowledge bit itself carries no data
					bit_cnt_reg <= 4'h0;
					if (state_reg == TWS_RACK) begin
						// Master acknowledge continues the read; no acknowledge ends it
						if (sda_in)
							state_reg <= TWS_IDLE;
						else
							state_reg <= TWS_RDATA;
					end
				end else if (bit_cnt_reg == 4'h7) begin
					// Eighth bit: the whole byte is in, so answer on the coming fall
					bit_cnt_reg <= `TWS_ACK_BIT_INDEX;
					case (state_reg)
						TWS_DEVADR: begin
							if (!dev_match || busy_sync_reg[1])
								state_reg <= TWS_IDLE;
							else begin
								ack_now_reg <= 1'b1;
								rd_mode_reg <= rx_byte[0];
								if (rx_byte[0])
									state_reg <= TWS_RDATA;
								else
									state_reg <= TWS_WORDAD;
								if (HI_BITS > 0 && !rx_byte[0])
									page_base_reg[ADDR_BITS-1:8] <= rx_byte[HI_BITS:1];
							end
						end
						TWS_WORDAD: begin
							ack_now_reg  <= 1'b1;
							addr_cnt_reg <= {page_base_reg[ADDR_BITS-1:8], rx_byte};
							state_reg    <= TWS_WDATA;
						end
						TWS_WDATA: begin
							ack_now_reg <= 1'b1;
							wr_word.addr <= 11'(addr_cnt_reg);
							wr_word.data <= rx_byte;
							wr_pending_reg <= 1'b1;
							if (!write_protect)
								mem[addr_cnt_reg] <= rx_byte;
							addr_cnt_reg[`TWS_COL_BITS-1:0] <= addr_cnt_reg[`TWS_COL_BITS-1:0] + 4'h1;
						end
						TWS_RDATA: begin
							state_reg    <= TWS_RACK;
							addr_cnt_reg <= addr_cnt_reg + 1'b1;
						end
						default: state_reg <= TWS_IDLE;
					endcase
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					shift_reg   <= rx_byte;
				end
			end
		end
	end

	// A seen STOP counts as idle: scl may never rise again to move the sequencer
	assign standby = (state_reg == TWS_IDLE || stop_seen_reg) && !busy_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Falling edge: drive data out; open-drain only

	logic        pull_low_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  rd_byte;

	assign rd_byte = mem[addr_cnt_reg];

	always_ff @(negedge scl or negedge resetn) begin
		if (!resetn) begin
			pull_low_reg <= 1'b0;
			tx_reg       <= `TWS_ERASED_BYTE;
		end else if (frame_reset) begin
			pull_low_reg <= 1'b0;
		end else if (ack_now_reg) begin
			pull_low_reg <= 1'b1;
			tx_reg       <= rd_byte;
		end else if (state_reg == TWS_RDATA && bit_cnt_reg == 4'h0) begin
			pull_low_reg <= ~rd_byte[7];
			tx_reg       <= {rd_byte[6:0], 1'b1};
		end else if (state_reg == TWS_RDATA && bit_cnt_reg < `TWS_ACK_BIT_INDEX) begin
			pull_low_reg <= ~tx_reg[7];
			tx_reg       <= {tx_reg[6:0], 1'b1};
		end else
			pull_low_reg <= 1'b0;
	end

	assign sda_out = 1'b0;
	assign sda_oe  = pull_low_reg;

endmodule : tws_eeprom_port

/* design/tws_defs.svh */
// Constants for the two-wire EEPROM slave port: addressing, geometry, timing.
// Assumes a 100 MHz system clock; included by the package and the port module.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

`define TWS_DEV_TYPE_CODE     4'ha
`define TWS_PAGE_BYTES        16
`define TWS_COL_BITS          4
`define TWS_CLK_HZ            100000000
`define TWS_PROG_TIME_MS      5
`define TWS_PROG_CYCLES       ((`TWS_PROG_TIME_MS * `TWS_CLK_HZ) / 1000)
`define TWS_ACK_BIT_INDEX     4'h8
`define TWS_ERASED_BYTE       8'hff

`endif

/* design/tws_pkg.sv */
// Types shared by the two-wire EEPROM slave port.
// Assumes tws_defs.svh sits beside it in the design folder.
`include "tws_defs.svh"

package tws_pkg;

	typedef enum logic [2:0] {
		TWS_IDLE   = 3'b000,
		TWS_DEVADR = 3'b001,
		TWS_WORDAD = 3'b010,
		TWS_WDATA  = 3'b011,
		TWS_RDATA  = 3'b100,
		TWS_RACK   = 3'b101
	} tws_state_type;

	// Last written address and byte, held in the link domain
	typedef struct packed {
		logic [10:0] addr;
		logic [7:0]  data;
	} tws_wr_type;

endpackage : tws_pkg

/* tb/tws_eeprom_port_monitor.sv */
// Checker for the two-wire EEPROM slave port, bound to its top module.
// Assumes clock_enable stays high, so the timer never stalls.
module tws_eeprom_port_monitor #(
	parameter int PROG_CYCLES = 50
) (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Link
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Control and status
	input wire logic write_protect,
	input wire logic programming_busy,
	input wire logic standby
);
	////////////////////////////////////////
	int   busy_cnt;
	logic oe_rise;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			busy_cnt <= 0;
		else
			busy_cnt <= programming_busy ? busy_cnt + 1 : 0;
	end
	// The pull may only change on a falling edge, so it must match what the rising edge saw
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn)
			oe_rise <= 1'b0;
		else
			oe_rise <= sda_oe;
	end
	drain_only_a: assert property (@(posedge clock) sda_out == 1'b0)
		else $error("data driven high");
	oe_hold_a: assert property (@(negedge scl) disable iff (!resetn) sda_oe == oe_rise)
		else $error("pull changed while clock high");
	busy_std_a: assert property (@(posedge clock) disable iff (!resetn)
		programming_busy |-> !standby) else $error("standby while busy");
	prog_max_a: assert property (@(posedge clock) disable iff (!resetn)
		busy_cnt <= PROG_CYCLES + 2) else $error("programming too long");
	prog_min_a: assert property (@(posedge clock) disable iff (!resetn)
		$fell(programming_busy) |-> busy_cnt >= PROG_CYCLES - 2 && standby) else $error("programming too short");
	protect_a: assert property (@(posedge clock) disable iff (!resetn)
		write_protect && $past(write_protect) |-> !$rose(programming_busy)) else $error("protected write ran");
	quiet_busy_a: assert property (@(posedge clock) disable iff (!resetn)
		programming_busy |-> !sda_oe) else $error("answered while busy");
	reset_vals_a: assert property (@(posedge clock)
		!resetn |-> !sda_oe && !programming_busy && standby) else $error("bad reset state");
	busy_c: cover property (@(posedge clock) $rose(programming_busy));
	done_c: cover property (@(posedge clock) $fell(programming_busy));
	ack_c: cover property (@(posedge scl) sda_oe);
endmodule : tws_eeprom_port_monitor

bind tws_eeprom_port tws_eeprom_port_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
	.clock(clock), .resetn(resetn), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
	.write_protect(write_protect), .programming_busy(programming_busy), .standby(standby));

/* tb/tws_master.sv */
// Two-wire bus master model: makes the 12 ns link clock and its own pull on the data line.
// Assumes the bench resolves the line with a pull-up; scl stands high between frames.
module tws_master (
	// Link
	output logic      scl,
	output logic      pull,
	input  wire logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	////////////////////////////////////////
	// Level is taken as scl rises; the device drives on the fall
	task automatic bit1(input logic b, output logic r);
		#3 pull = !b;
		#3 scl = 1'b1;
		r = line;
		#6 scl = 1'b0;
	endtask : bit1
	task automatic start;
		#3.3 pull = 1'b0;
		#3 scl = 1'b1;
		#3 pull = 1'b1;
		#3 scl = 1'b0;
	endtask : start
	task automatic stop;
		#3 pull = 1'b1;
		#3 scl = 1'b1;
		#3 pull = 1'b0;
	endtask : stop
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit1(b[i], r);
		bit1(1'b1, r);
		ack = !r;
	endtask : wr
	task automatic rd(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit1(1'b1, b[i]);
		bit1(last, r);
	endtask : rd
endmodule : tws_master

/* tb/two_wire_eeprom_slave_port_bench.sv */
// Self-checking bench for the two-wire EEPROM slave port, smallest variant.
// Assumes the master model on the link; the wire is resolved here with a pull-up.
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("MISMATCH %0t got %h want %h", $time, a, e); end end
module two_wire_eeprom_slave_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0, resetn = 1'b1, wp = 1'b0;
	logic       top = 1'b1, mid = 1'b0, low = 1'b1;
	logic       scl, pull, line, sda_out, sda_oe, busy, standby, ack;
	logic [7:0] d;
	logic [7:0] bad [3] = '{8'hac, 8'hba, 8'ha2};
	int         n_errors = 0, n_compared = 0;
	assign line = !(pull || (sda_oe && !sda_out));
	always #5 clock = !clock;
	tws_master m (.scl(scl), .pull(pull), .line(line));
	tws_eeprom_port #(.ADDR_BITS(9), .PROG_CYCLES(50)) dut (
		.clock(clock), .resetn(resetn), .clock_enable(1'b1), .scl(scl), .sda_in(line),
		.sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_top(top), .chip_select_bit_mid(mid),
		.chip_select_bit_low(low), .write_protect(wp), .programming_busy(busy), .standby(standby));
	////////////////////////////////////////
	task automatic send(input logic [7:0] b, input logic e);
		m.wr(b, ack);
		`CHK(ack, e)
	endtask : send
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 200 && busy !== v; i++)
			@(negedge clock);
		`CHK(busy, v)
	endtask : wait_busy
	// Dummy write sets the counter, then a repeated start turns to reading
	task automatic rd_at(input logic [7:0] wa);
		m.start();
		send(8'haa, 1'b1);
		send(wa, 1'b1);
		m.start();
		send(8'hab, 1'b1);
	endtask : rd_at
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	initial begin
		#20000;
		n_errors++;
		end_of_test();
	end
	initial begin
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(negedge clock);
		`CHK(standby, 1'b1)
		$display("test reset done");
		// Last column first, so the page wraps; bit one of the address gives word bit eight
		m.start();
		send(8'haa, 1'b1);
		send(8'haf, 1'b1);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		send(8'h33, 1'b1);
		m.stop();
		wait_busy(1'b1);
		`CHK(standby, 1'b0)
		$display("test write done");
		m.start();
		send(8'haa, 1'b0);
		m.stop();
		wait_busy(1'b0);
		`CHK(standby, 1'b1)
		$display("test poll done");
		rd_at(8'ha0);
		m.rd(1'b0, d);
		`CHK(d, 8'h22)
		m.rd(1'b1, d);
		`CHK(d, 8'h33)
		m.stop();
		repeat (5) @(negedge clock);
		`CHK(standby, 1'b1)
		$display("test read done");
		@(posedge clock) wp <= 1'b1;
		m.start();
		send(8'haa, 1'b1);
		send(8'ha0, 1'b1);
		send(8'h55, 1'b1);
		m.stop();
		repeat (5) @(negedge clock);
		`CHK(busy, 1'b0)
		rd_at(8'ha0);
		m.rd(1'b1, d);
		`CHK(d, 8'h22)
		m.stop();
		$display("test protect done");
		foreach (bad[i]) begin
			m.start();
			send(bad[i], 1'b0);
			m.stop();
		end
		$display("test address done");
		end_of_test();
	end
endmodule : two_wire_eeprom_slave_port_bench
